/* inc/tkc_pkg.sv */
// Package for the timekeeping counter chain
package tkc_pkg;
	localparam int unsigned TKC_OSC_DIV = 32;
	localparam int unsigned TKC_PRESCALE = 8;
	localparam int unsigned TKC_TIMER_W = 16;
	localparam int unsigned TKC_HALF_W = 16;
	localparam logic [4:0] TKC_OSC_DIV_LAST = 5'h1f;
	localparam logic [2:0] TKC_PRESCALE_LAST = 3'h7;
	localparam logic [15:0] TKC_TIMER_MAX = 16'hffff;
	localparam logic [15:0] TKC_HALF_MAX = 16'hffff;
	localparam logic [2:0] TKC_SYNC_RST = 3'h0;
	localparam logic TKC_PREV_RST = 1'h0;
	localparam logic [4:0] TKC_DIV_RST = 5'h0;
	localparam logic [2:0] TKC_PRE_RST = 3'h0;
	localparam logic TKC_EVENT_RST = 1'h0;

	typedef struct packed {
		logic [15:0] upper;
		logic [15:0] lower;
	} tkc_count_t;

	typedef struct packed {
		logic [15:0] timer;
		logic [15:0] reload;
		logic [15:0] upper;
		logic [15:0] lower;
	} tkc_load_t;

	typedef struct packed {
		logic timer;
		logic reload;
		logic upper;
		logic lower;
	} tkc_load_en_t;
endpackage

/* rtl/tkc_chain.sv */
// Timekeeping counter chain: oscillator divider, prescaler, reload timer, long counter
`timescale 1ns/1ns
// Function
// [R1] Chain ticks at oscillator over 32, independent of system clock mode; here clk_en low gates off the oscillator edge and stops it.
// [R2] Three stages: fixed 8:1 prescaler, reload timer, long counter.
// [R3] Middle stage is a 16-bit timer reloaded from a written value.
// [R4] Final stage is a 32-bit counter read as upper and lower halves.
// [R5] Every stage counts upward only.
// [R6] Reload timer and long counter together form a 48-bit count.
// [R7] A periodic event pulse is derived from the chain.
// [R8] Counter contents and reload value survive every reset.
// [R9] Timer overflow reloads it and bumps the counter; lower carries into upper.
module tkc_chain
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic osc_tick,
	input wire tkc_pkg::tkc_load_t load_val,
	input wire tkc_pkg::tkc_load_en_t load_en,
	output tkc_pkg::tkc_count_t timekeeping_count,
	output logic [15:0] prescaled_reload_timer,
	output logic [15:0] reload_value,
	output logic [47:0] long_count,
	output logic timer_event,
	output logic long_event
);
	import tkc_pkg::*;

	logic [2:0] osc_sync;
	logic osc_level_ok;
	logic osc_prev;
	logic next_osc_prev;
	logic osc_edge;
	logic [4:0] osc_div;
	logic [4:0] next_osc_div;
	logic rtc_tick;
	logic [2:0] pre_div;
	logic [2:0] next_pre_div;
	logic pre_tick;
	logic timer_ovf;
	logic lower_ovf;
	logic [15:0] next_reload;
	logic [15:0] next_timer;
	logic [15:0] count_lower;
	logic [15:0] next_lower;
	logic [15:0] count_upper;
	logic [15:0] next_upper;
	logic [47:0] next_long;
	logic next_timer_event;
	logic next_long_event;

	// Single upward step shared by the timer and both count halves [R5]
	function automatic logic [15:0] tkc_inc16(input logic [15:0] value);
		tkc_inc16 = value + 16'h1;
	endfunction

	// Terminal test shared by the timer and the lower half
	function automatic logic tkc_at_max(input logic [15:0] value, input logic [15:0] limit);
		tkc_at_max = (value == limit);
	endfunction

	// Oscillator comes from its own domain; level trusted once stages 2 and 3 agree
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			osc_sync <= TKC_SYNC_RST;
		else if (clk_en)
			osc_sync <= {osc_sync[1:0], osc_tick};
	end

	assign osc_level_ok = (osc_sync[2] == osc_sync[1]);

	// Low after reset like the idle pin, so no false edge follows reset
	always_comb
	begin
		next_osc_prev = osc_prev;
		if (clk_en && osc_level_ok)
			next_osc_prev = osc_sync[2];
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			osc_prev <= TKC_PREV_RST;
		else
			osc_prev <= next_osc_prev;
	end

	assign osc_edge = clk_en && osc_level_ok && osc_sync[2] && !osc_prev;

	// Dedicated divide by 32, fed only by the oscillator edge [R1]
	always_comb
	begin
		next_osc_div = osc_div;
		if (osc_edge)
			next_osc_div = osc_div + 5'h1; // [R5]
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			osc_div <= TKC_DIV_RST;
		else
			osc_div <= next_osc_div;
	end

	assign rtc_tick = osc_edge && (osc_div == TKC_OSC_DIV_LAST); // [R1]

	// Fixed 8:1 prescaler; phase loss on reset costs under one timer step [R2]
	always_comb
	begin
		next_pre_div = pre_div;
		if (rtc_tick)
			next_pre_div = pre_div + 3'h1; // [R5]
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			pre_div <= TKC_PRE_RST;
		else
			pre_div <= next_pre_div;
	end

	assign pre_tick = rtc_tick && (pre_div == TKC_PRESCALE_LAST); // [R2]
	assign timer_ovf = pre_tick && tkc_at_max(prescaled_reload_timer, TKC_TIMER_MAX); // [R9]
	assign lower_ovf = timer_ovf && tkc_at_max(count_lower, TKC_HALF_MAX); // [R9]

	// No reset term on these registers so time survives every reset [R8]
	always_comb
	begin
		next_reload = reload_value;
		if (clk_en && load_en.reload)
			next_reload = load_val.reload; // [R3]
	end

	always_ff @(posedge mclk)
	begin
		reload_value <= next_reload; // [R8]
	end

	// Software write wins over a tick or a reload in the same cycle
	always_comb
	begin
		next_timer = prescaled_reload_timer;
		if (clk_en && load_en.timer)
			next_timer = load_val.timer; // [R3]
		else if (timer_ovf)
			next_timer = reload_value; // [R9] [R3]
		else if (pre_tick)
			next_timer = tkc_inc16(prescaled_reload_timer); // [R5] [R2]
	end

	always_ff @(posedge mclk)
	begin
		prescaled_reload_timer <= next_timer; // [R8]
	end

	always_comb
	begin
		next_lower = count_lower;
		if (clk_en && load_en.lower)
			next_lower = load_val.lower;
		else if (timer_ovf)
			next_lower = tkc_inc16(count_lower); // [R9] [R4] [R5]
	end

	always_ff @(posedge mclk)
	begin
		count_lower <= next_lower; // [R8]
	end

	always_comb
	begin
		next_upper = count_upper;
		if (clk_en && load_en.upper)
			next_upper = load_val.upper;
		else if (lower_ovf)
			next_upper = tkc_inc16(count_upper); // [R9] [R4]
	end

	always_ff @(posedge mclk)
	begin
		count_upper <= next_upper; // [R8]
	end

	// Halves kept apart so each has one writer
	assign timekeeping_count = {count_upper, count_lower}; // [R4]

	// Combined 48-bit view, one cycle behind its sources [R6]
	always_comb
	begin
		next_long = long_count;
		if (clk_en)
			next_long = {count_upper, count_lower, prescaled_reload_timer}; // [R6]
	end

	always_ff @(posedge mclk)
	begin
		long_count <= next_long;
	end

	// Event pulses carry a reset so they are never unknown at start [R7]
	always_comb
	begin
		next_timer_event = timer_event;
		next_long_event = long_event;
		if (clk_en)
		begin
			next_timer_event = timer_ovf; // [R7]
			next_long_event = lower_ovf; // [R9]
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timer_event <= TKC_EVENT_RST;
			long_event <= TKC_EVENT_RST;
		end
		else
		begin
			timer_event <= next_timer_event;
			long_event <= next_long_event;
		end
	end
endmodule

/* tb/tkc_chain_sva.sv */
// Assertions for the timekeeping counter chain
`timescale 1ns/1ns
module tkc_chain_sva (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire tkc_pkg::tkc_load_t load_val,
	input wire tkc_pkg::tkc_load_en_t load_en,
	input wire tkc_pkg::tkc_count_t timekeeping_count,
	input wire logic [15:0] prescaled_reload_timer,
	input wire logic [15:0] reload_value,
	input wire logic [47:0] long_count,
	input wire logic timer_event,
	input wire logic long_event
);
	bit [1:0] live;
	wire [15:0] tm = prescaled_reload_timer;
	// No reset on counters, so wait for a full preload
	always_ff @(posedge mclk) live <= {live[0], live[0] | (&load_en)};
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst || !live[1]);
	tmr_ld_a: assert property (clk_en && load_en.timer |=> tm == $past(load_val.timer))
		else $error("timer load");
	tmr_up_a: assert property (!load_en && tm != 16'hffff |=> 16'(tm - $past(tm)) < 2)
		else $error("timer step");
	ev_rld_a: assert property (timer_event |-> tm == reload_value) else $error("reload");
	cnt_up_a: assert property (!load_en |=>
		32'(timekeeping_count - $past(timekeeping_count)) < 2) else $error("count step");
	ev_one_a: assert property (timer_event && clk_en |=> !timer_event) else $error("pulse");
	lng_cat_a: assert property (clk_en |=>
		long_count == {$past(timekeeping_count), $past(tm)}) else $error("long view");
	lev_car_a: assert property (long_event |->
		timer_event && timekeeping_count.lower == 16'h0) else $error("carry");
	cover property (timer_event);
	cover property (long_event);
	cover property (load_en.timer);
	cover property (tm == 16'hffff);
endmodule
bind tkc_chain tkc_chain_sva u_sva (.*);

/* tb/tkc_chain_tb.sv */
// Bench for the timekeeping counter chain
`timescale 1ns/1ns
`define CHK(n, e, g) n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end
module tkc_chain_tb;
	logic mclk = 0, sys_rst = 1, osc_tick = 0, en = 1, tev, lev;
	logic [63:0] ld = 64'hffff_1234_0007_ffff;
	logic [3:0] le = '0;
	wire [63:0] w;
	wire [47:0] lc;
	int n_fail = 0, n_compared = 0, n_tev = 0, n_lev = 0;
	tkc_chain dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(en), .osc_tick(osc_tick),
		.load_val(ld), .load_en(le), .timekeeping_count(w[63:32]), .long_count(lc),
		.prescaled_reload_timer(w[31:16]), .reload_value(w[15:0]), .timer_event(tev),
		.long_event(lev));
	initial forever #25 mclk = ~mclk;
	// Pulses counted at the falling edge, where they have settled
	always @(negedge mclk)
	begin
		if (tev === 1'b1)
			n_tev++;
		if (lev === 1'b1)
			n_lev++;
	end
	// Edges on falling mclk, three cycles per level
	task osc(int n);
		repeat (2 * n) #150 osc_tick = ~osc_tick;
		#300;
	endtask
	// Preload, then 255 edges leave the timer alone and the 256th wraps it
	task overflow;
		le = '1;
		#50 le = '0;
		osc(255);
		`CHK("loaded", 64'h0007_ffff_ffff_1234, w)
		`CHK("no pulse", 32'h0, n_tev)
		osc(1);
		`CHK("wrap", 64'h0008_0000_1234_1234, w)
		`CHK("wrap long", 48'h0008_0000_1234, lc)
		`CHK("timer events", 32'h1, n_tev)
		`CHK("long events", 32'h1, n_lev)
	endtask
	task retain;
		sys_rst = 1;
		#50 sys_rst = 0;
		osc(255);
		`CHK("kept", 64'h0008_0000_1234_1234, w)
		osc(1);
		`CHK("step", 64'h0008_0000_1235_1234, w)
		`CHK("step long", 48'h0008_0000_1235, lc)
		`CHK("step events", 32'h1, n_tev)
	endtask
	// Enable low: a full period of edges and a timer write change nothing
	task freeze;
		en = 0;
		ld[63:48] = 16'h5555;
		le = 4'h8;
		#50 le = '0;
		osc(256);
		`CHK("frozen", 64'h0008_0000_1235_1234, w)
		`CHK("frozen long", 48'h0008_0000_1235, lc)
		en = 1;
		osc(256);
		`CHK("resumed", 64'h0008_0000_1236_1234, w)
		`CHK("resumed events", 32'h1, n_tev)
	endtask
	task final_report;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#300 sys_rst = 0;
		overflow;
		retain;
		freeze;
		final_report;
	end
endmodule
